// ---- include/tmc_pkg.sv ----
// Constants shared by the temperature monitor control logic.
package tmc_pkg;
   localparam logic [7:0] RD_LOCAL = 8'h00;
   localparam logic [7:0] RD_REMOTE = 8'h01;
   localparam logic [7:0] RD_STATUS = 8'h02;
   localparam logic [7:0] RD_CONFIG = 8'h03;
   localparam logic [7:0] RD_RATE = 8'h04;
   localparam logic [7:0] RD_LHI = 8'h05;
   localparam logic [7:0] RD_LLO = 8'h06;
   localparam logic [7:0] RD_RHI = 8'h07;
   localparam logic [7:0] RD_RLO = 8'h08;
   localparam logic [7:0] WR_CONFIG = 8'h09;
   localparam logic [7:0] WR_RATE = 8'h0a;
   localparam logic [7:0] WR_LHI = 8'h0b;
   localparam logic [7:0] WR_LLO = 8'h0c;
   localparam logic [7:0] WR_RHI = 8'h0d;
   localparam logic [7:0] WR_RLO = 8'h0e;
   localparam logic [7:0] WR_ONESHOT = 8'h0f;
   localparam logic [7:0] RW_OFFSET = 8'h11;
   localparam logic [7:0] RD_MAKER = 8'hfe;
   localparam logic [7:0] RD_REV = 8'hff;
   localparam int CFG_MASK_BIT = 7;
   localparam int CFG_STANDBY_PIN_N_BIT = 6;
   localparam int ST_BUSY_BIT = 7;
   localparam logic [7:0] RST_TEMP = 8'h80;
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h02;
   localparam logic [7:0] RST_HI = 8'h7f;
   localparam logic [7:0] RST_LO = 8'hc9;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_INVALID = 8'h00;
   localparam logic [6:0] RST_SLAVE = 7'h2a;
   // Arbitrary identity values, not those of any real part.
   localparam logic [7:0] ID_MAKER = 8'h5a;
   localparam logic [7:0] ID_REV = 8'h10;
   localparam logic [1:0] PIN_LOW = 2'h0;
   localparam logic [1:0] PIN_OPEN = 2'h1;
   localparam logic [1:0] PIN_HIGH = 2'h2;
   localparam logic [3:0] ADDR_HI_LOW = 4'h3;
   localparam logic [3:0] ADDR_HI_OPEN = 4'h5;
   localparam logic [3:0] ADDR_HI_HIGH = 4'h9;
   localparam int CLK_HZ = 25000000;
   localparam int FAST_CONV_MS = 125;
   localparam int FAST_CONV_CYC = CLK_HZ / 1000 * FAST_CONV_MS;
   localparam logic [2:0] RATE_MAX = 3'h7;
   typedef enum logic [2:0] {
      TMC_IDLE, TMC_ADDR, TMC_AACK, TMC_WR, TMC_WACK, TMC_RD, TMC_RACK
   } tmc_bus_t;
endpackage

// ---- verilog/tmc_top.sv ----
// Control, register and serial slave logic of a two-channel thermometer.
// Overview of operation
// - Config bit 6: 0 run, 1 standby
// - Standby input pin low forces standby
// - Value registers hold during standby
// - Config bit 7 masks the alert output
// - Rate code divides fastest conversion rate
// - Strict greater/less-than limit comparisons
// - Four signed read/write limit registers
// - Signed offset added to remote result
// - Offset register clears to zero
// - One-shot write in config-bit standby converts once; pin standby blocks it
// - One-shot data byte ignored, not stored
// - Serial interface is slave only
// - Two three-level pins pick nine addresses
// - Address pins latched once after reset
// - Shift in seven-bit address and direction
// - Matching slave acknowledges, others stay idle
// - Direction bit selects write or read
// - First written byte loads register pointer
// - Separate read and write register addresses, except the shared offset address
// - Entering standby aborts running conversion
// - Any flag set asserts the alert
`timescale 1ns/1ps
`default_nettype none
module tmc_top #(
   parameter int BASE_CYCLES = tmc_pkg::FAST_CONV_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Serial bus, clock sampled and data open drain
   input wire logic SERIAL_CLOCK_LINE,
   input wire logic SERIAL_DATA_LINE_IN,
   output logic SERIAL_DATA_LINE_OUT,
   output logic SERIAL_DATA_LINE_OE_N,
   // Pins
   input wire logic STANDBY_PIN_N,
   input wire logic [1:0] ADDR_SELECT_PIN_A,
   input wire logic [1:0] ADDR_SELECT_PIN_B,
   output logic ALERT_OUT,
   output logic ALERT_OE_N,
   // Measurement converter
   output logic ADC_START,
   output logic ADC_ABORT,
   input wire logic ADC_DONE,
   input wire logic [7:0] ADC_LOCAL,
   input wire logic [7:0] ADC_REMOTE,
   input wire logic ADC_OPEN
);
   import tmc_pkg::*;

   logic [1:0] scl_s, sda_s, standby_pin_n_s;
   logic [1:0] pa_s0, pa_s1, pb_s0, pb_s1;
   logic scl_d, sda_d;
   logic [1:0] strap_cnt;
   logic [6:0] slave_addr;
   tmc_bus_t st;
   logic [3:0] cnt;
   logic [7:0] sh, ptr;
   logic rw, first, mack;
   logic [7:0] cfg, rate, lhi, llo, rhi, rlo, offset;
   logic [7:0] loc_t, rem_t;
   logic [4:0] flags;
   logic busy, oneshot_run;
   logic [$clog2(BASE_CYCLES+1)-1:0] base_cnt;
   logic [6:0] div_cnt;

   // Pin A picks the upper four bits; both pins add into the lower three.
   function automatic logic [6:0] addr_lookup(input logic [1:0] a,
                                              input logic [1:0] b);
      logic [3:0] hi;
      logic [2:0] lo;
      hi = (a == PIN_LOW) ? ADDR_HI_LOW :
           (a == PIN_OPEN) ? ADDR_HI_OPEN : ADDR_HI_HIGH;
      lo = (a == PIN_LOW) ? 3'h0 : (a == PIN_OPEN) ? 3'h1 : 3'h4;
      lo = lo + ((b == PIN_LOW) ? 3'h0 : (b == PIN_OPEN) ? 3'h1 : 3'h2);
      return {hi, lo};
   endfunction

   // Read decode uses only the read addresses of each register.
   function automatic logic [7:0] rd_sel(input logic [7:0] p);
      case (p)
         RD_LOCAL: rd_sel = loc_t;
         RD_REMOTE: rd_sel = rem_t;
         RD_STATUS: rd_sel = {busy, flags, 2'h0};
         RD_CONFIG: rd_sel = cfg;
         RD_RATE: rd_sel = rate;
         RD_LHI: rd_sel = lhi;
         RD_LLO: rd_sel = llo;
         RD_RHI: rd_sel = rhi;
         RD_RLO: rd_sel = rlo;
         RW_OFFSET: rd_sel = offset;
         RD_MAKER: rd_sel = ID_MAKER;
         RD_REV: rd_sel = ID_REV;
         default: rd_sel = RST_INVALID;
      endcase
   endfunction

   // Edge and condition decode on the synchronised bus lines.
   wire scl = scl_s[1];
   wire sda = sda_s[1];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_det = scl & scl_d & sda_d & ~sda;
   wire stop_det = scl & scl_d & ~sda_d & sda;
   wire addr_hit = (sh[7:1] == slave_addr);
   // A process, not a wire, so that the read mux also follows changes of
   // the registers that the function reads, not just of the pointer.
   logic [7:0] rd_data;
   always_comb rd_data = rd_sel(ptr);
   wire byte_done = (st == TMC_WR) && scl_fall && (cnt == 4'h8);
   wire reg_wr = byte_done && !first;
   wire status_rd = (st == TMC_AACK || st == TMC_RACK) && scl_fall
                    && rw && (st == TMC_AACK || mack)
                    && (ptr == RD_STATUS);

   // Conversion control.
   wire standby = cfg[CFG_STANDBY_PIN_N_BIT] | ~standby_pin_n_s[1];
   wire [2:0] rate_code = rate[2:0];
   wire [6:0] div_top = 7'(({7'h0, 1'b1} << (RATE_MAX - rate_code)) - 1);
   wire base_tick = (base_cnt == BASE_CYCLES - 1);
   wire period_tick = base_tick && (div_cnt >= div_top);
   wire oneshot_wr = reg_wr && (ptr == WR_ONESHOT);
   wire oneshot_go = oneshot_wr && cfg[CFG_STANDBY_PIN_N_BIT] && standby_pin_n_s[1];
   wire run_go = period_tick && !standby && !busy;
   wire abort = busy && (oneshot_run ? ~standby_pin_n_s[1] : standby);
   wire done_ok = busy && ADC_DONE && !abort;
   wire [7:0] rem_new = ADC_REMOTE + offset;
   wire [4:0] cond = {$signed(loc_t) > $signed(lhi),
                      $signed(loc_t) < $signed(llo),
                      $signed(rem_t) > $signed(rhi),
                      $signed(rem_t) < $signed(rlo),
                      flags[0]};
   wire [4:0] set_new = {$signed(ADC_LOCAL) > $signed(lhi),
                         $signed(ADC_LOCAL) < $signed(llo),
                         $signed(rem_new) > $signed(rhi),
                         $signed(rem_new) < $signed(rlo),
                         ADC_OPEN};
   // A new result sets flags even when a status read clears them.
   wire [4:0] next_flags = (done_ok ? set_new : 5'h0)
                           | (status_rd ? (cond & {4'hf, ADC_OPEN & 1'b0})
                                        : flags);
   wire next_alert_n = ~(|flags & ~cfg[CFG_MASK_BIT]);

   // Synchronisers; the first stage feeds only the second.
   always_ff @(posedge CLK) begin
      scl_s <= {scl_s[0], SERIAL_CLOCK_LINE};
      sda_s <= {sda_s[0], SERIAL_DATA_LINE_IN};
      standby_pin_n_s <= {standby_pin_n_s[0], STANDBY_PIN_N};
      pa_s0 <= ADDR_SELECT_PIN_A;
      pa_s1 <= pa_s0;
      pb_s0 <= ADDR_SELECT_PIN_B;
      pb_s1 <= pb_s0;
      scl_d <= scl;
      sda_d <= sda;
   end

   // Straps are caught once, after the synchronisers have filled.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         strap_cnt <= 2'h0;
         slave_addr <= RST_SLAVE;
      end else if (strap_cnt != 2'h3) begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == 2'h2) begin
            slave_addr <= addr_lookup(pa_s1, pb_s1);
         end
      end
   end

   // Slave-only bus engine: it never drives the clock line.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st <= TMC_IDLE;
         cnt <= 4'h0;
         sh <= 8'h0;
         ptr <= 8'h0;
         rw <= 1'b0;
         first <= 1'b0;
         mack <= 1'b0;
         SERIAL_DATA_LINE_OE_N <= 1'b1;
         SERIAL_DATA_LINE_OUT <= 1'b0;
      end else if (start_det) begin
         st <= TMC_ADDR;
         cnt <= 4'h0;
         SERIAL_DATA_LINE_OE_N <= 1'b1;
      end else if (stop_det) begin
         st <= TMC_IDLE;
         SERIAL_DATA_LINE_OE_N <= 1'b1;
      end else begin
         case (st)
            TMC_ADDR: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  if (addr_hit) begin
                     SERIAL_DATA_LINE_OE_N <= 1'b0;
                     rw <= sh[0];
                     st <= TMC_AACK;
                  end else begin
                     st <= TMC_IDLE;
                  end
               end
            end
            TMC_AACK: begin
               if (scl_fall) begin
                  cnt <= 4'h0;
                  first <= 1'b1;
                  if (rw) begin
                     sh <= rd_data;
                     SERIAL_DATA_LINE_OE_N <= rd_data[7];
                     st <= TMC_RD;
                  end else begin
                     SERIAL_DATA_LINE_OE_N <= 1'b1;
                     st <= TMC_WR;
                  end
               end
            end
            TMC_WR: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda};
                  cnt <= cnt + 4'h1;
               end else if (byte_done) begin
                  SERIAL_DATA_LINE_OE_N <= 1'b0;
                  st <= TMC_WACK;
                  if (first) begin
                     ptr <= sh;
                     first <= 1'b0;
                  end
               end
            end
            TMC_WACK: begin
               if (scl_fall) begin
                  SERIAL_DATA_LINE_OE_N <= 1'b1;
                  cnt <= 4'h0;
                  st <= TMC_WR;
               end
            end
            TMC_RD: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], 1'b0};
                  cnt <= cnt + 4'h1;
               end else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     SERIAL_DATA_LINE_OE_N <= 1'b1;
                     st <= TMC_RACK;
                  end else begin
                     SERIAL_DATA_LINE_OE_N <= sh[7];
                  end
               end
            end
            TMC_RACK: begin
               if (scl_rise) begin
                  mack <= ~sda;
               end else if (scl_fall) begin
                  if (mack) begin
                     sh <= rd_data;
                     cnt <= 4'h0;
                     SERIAL_DATA_LINE_OE_N <= rd_data[7];
                     st <= TMC_RD;
                  end else begin
                     st <= TMC_IDLE;
                  end
               end
            end
            default: begin
               SERIAL_DATA_LINE_OE_N <= 1'b1;
            end
         endcase
      end
   end

   // Register writes land only at the write addresses.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cfg <= RST_CONFIG;
         rate <= RST_RATE;
         lhi <= RST_HI;
         llo <= RST_LO;
         rhi <= RST_HI;
         rlo <= RST_LO;
         offset <= RST_OFFSET;
      end else if (reg_wr) begin
         case (ptr)
            WR_CONFIG: cfg <= {sh[7:6], 6'h0};
            WR_RATE: rate <= sh;
            WR_LHI: lhi <= sh;
            WR_LLO: llo <= sh;
            WR_RHI: rhi <= sh;
            WR_RLO: rlo <= sh;
            RW_OFFSET: offset <= sh;
            default: cfg <= cfg;
         endcase
      end
   end

   // Conversion timing: a base tick at the fastest rate, then a divider.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         base_cnt <= '0;
         div_cnt <= 7'h0;
      end else begin
         base_cnt <= base_tick ? '0 : base_cnt + 1'b1;
         if (period_tick) begin
            div_cnt <= 7'h0;
         end else if (base_tick) begin
            div_cnt <= div_cnt + 7'h1;
         end
      end
   end

   // Converter handshake, results and flags.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         busy <= 1'b0;
         oneshot_run <= 1'b0;
         ADC_START <= 1'b0;
         ADC_ABORT <= 1'b0;
         loc_t <= RST_TEMP;
         rem_t <= RST_TEMP;
         flags <= 5'h0;
         ALERT_OE_N <= 1'b1;
         ALERT_OUT <= 1'b0;
      end else begin
         ADC_START <= (run_go || oneshot_go) && !busy;
         ADC_ABORT <= abort;
         flags <= next_flags;
         ALERT_OE_N <= next_alert_n;
         if (abort || done_ok) begin
            busy <= 1'b0;
            oneshot_run <= 1'b0;
         end else if (!busy && (run_go || oneshot_go)) begin
            busy <= 1'b1;
            oneshot_run <= oneshot_go;
         end
         if (done_ok) begin
            loc_t <= ADC_LOCAL;
            rem_t <= rem_new;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/tmc_top_sva.sv ----
// Pin-level checks for the thermometer control block.
`timescale 1ns/1ps
`default_nettype none
module tmc_top_sva (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Pins
   input wire logic SERIAL_CLOCK_LINE,
   input wire logic SERIAL_DATA_LINE_OUT,
   input wire logic SERIAL_DATA_LINE_OE_N,
   input wire logic STANDBY_PIN_N,
   input wire logic ALERT_OUT,
   // Converter
   input wire logic ADC_START,
   input wire logic ADC_ABORT,
   input wire logic ADC_DONE
);
   logic busy;
   logic [7:0] low_run;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   always_ff @(posedge CLK) begin
      if (SYS_RST || ADC_DONE || ADC_ABORT) busy <= 1'b0;
      else if (ADC_START) busy <= 1'b1;
   end
   // A stuck pull-down would hang the whole bus, so its length is bounded.
   always_ff @(posedge CLK) begin
      if (SYS_RST || SERIAL_DATA_LINE_OE_N) low_run <= 8'h00;
      else if (low_run != 8'hff) low_run <= low_run + 8'h01;
   end
   a_sda_pull_only: assert property (!SERIAL_DATA_LINE_OUT)
      else $error("data line driven high");
   a_alert_pull_only: assert property (!ALERT_OUT)
      else $error("alert driven high");
   a_start_one_cycle: assert property (ADC_START |=> !ADC_START)
      else $error("start pulse too long");
   a_one_conv_only: assert property (ADC_START |-> !busy)
      else $error("start while converting");
   a_pin_blocks_start: assert property (!STANDBY_PIN_N [*5] |-> !ADC_START)
      else $error("start in pin standby");
   a_pin_aborts_conv: assert property (!STANDBY_PIN_N [*6] |-> !busy)
      else $error("conversion kept in standby");
   a_idle_bus_free: assert property (SERIAL_CLOCK_LINE [*8] |-> SERIAL_DATA_LINE_OE_N)
      else $error("drive on idle bus");
   a_drive_clk_low: assert property ($changed(SERIAL_DATA_LINE_OE_N) |-> !SERIAL_CLOCK_LINE)
      else $error("drive change with clock high");
   a_drive_bounded: assert property (low_run < 8'd80)
      else $error("data line held too long");
endmodule
bind tmc_top tmc_top_sva u_sva (
   .CLK(CLK),
   .SYS_RST(SYS_RST),
   .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE),
   .SERIAL_DATA_LINE_OUT(SERIAL_DATA_LINE_OUT),
   .SERIAL_DATA_LINE_OE_N(SERIAL_DATA_LINE_OE_N),
   .STANDBY_PIN_N(STANDBY_PIN_N),
   .ALERT_OUT(ALERT_OUT),
   .ADC_START(ADC_START),
   .ADC_ABORT(ADC_ABORT),
   .ADC_DONE(ADC_DONE)
);
`default_nettype wire

// ---- test/tmc_host_model.sv ----
// Bus master model: bit-level start, stop and byte transfer tasks.
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
   // Timing reference
   input wire logic clk,
   // Bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Data moves mid low phase so no edge can pass for start or stop.
   task automatic bit_io(input logic b, output logic r);
      hw(2);
      sda_low = ~b;
      hw(2);
      scl = 1'b1;
      hw(4);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      hw(4);
      sda_low = 1'b1;
      hw(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      hw(2);
      sda_low = 1'b1;
      hw(2);
      scl = 1'b1;
      hw(4);
      sda_low = 1'b0;
      hw(4);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ai, ack);
   endtask
endmodule
`default_nettype wire

// ---- test/tmc_top_tb.sv ----
// Self-checking bench for the thermometer control block.
`timescale 1ns/1ps
`default_nettype none
module tmc_top_tb;
   import tmc_pkg::*;
   localparam logic [6:0] DEV = 7'h2a;
   localparam logic [7:0] RA [11] = '{RD_LOCAL, RD_REMOTE, RD_CONFIG,
      RD_RATE, RD_LHI, RD_LLO, RD_RHI, RD_RLO, RW_OFFSET, 8'h10, WR_CONFIG};
   localparam logic [7:0] RE [11] = '{8'h80, 8'h80, 8'h00, 8'h02, 8'h7f,
      8'hc9, 8'h7f, 8'hc9, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WA [7] = '{WR_CONFIG, WR_RATE, WR_LHI, WR_LLO,
      WR_RHI, WR_RLO, RW_OFFSET};
   localparam logic [7:0] WB [7] = '{RD_CONFIG, RD_RATE, RD_LHI, RD_LLO,
      RD_RHI, RD_RLO, RW_OFFSET};
   localparam logic [7:0] WD [7] = '{8'hff, 8'h07, 8'h20, 8'hf6, 8'h40,
      8'h80, 8'hfc};
   localparam logic [7:0] WE [7] = '{8'hc0, 8'h07, 8'h20, 8'hf6, 8'h40,
      8'h80, 8'hfc};
   logic clk, rst, standby_pin_n_n, scl, m_low, oe_n, alert_n, start, abort;
   logic adc_done = 1'b0;
   logic adc_open = 1'b0;
   logic [3:0] cnt = 4'd0;
   logic [1:0] pin_a, pin_b;
   logic [7:0] loc, rem, q;
   logic ack;
   wire sda;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   assign sda = ~(m_low | ~oe_n);
   tmc_top #(.BASE_CYCLES(20)) DUT (.CLK(clk), .SYS_RST(rst),
      .SERIAL_CLOCK_LINE(scl), .SERIAL_DATA_LINE_IN(sda),
      .SERIAL_DATA_LINE_OUT(), .SERIAL_DATA_LINE_OE_N(oe_n),
      .STANDBY_PIN_N(standby_pin_n_n), .ADDR_SELECT_PIN_A(pin_a),
      .ADDR_SELECT_PIN_B(pin_b), .ALERT_OUT(), .ALERT_OE_N(alert_n),
      .ADC_START(start), .ADC_ABORT(abort), .ADC_DONE(adc_done),
      .ADC_LOCAL(loc), .ADC_REMOTE(rem), .ADC_OPEN(adc_open));
   tmc_host_model M (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Converter stand-in: six cycles per result, dropped on abort.
   always @(negedge clk) begin
      adc_done <= 1'b0;
      if (start) cnt <= 4'd6;
      else if (abort) cnt <= 4'd0;
      else if (cnt == 4'd1) begin
         adc_done <= 1'b1;
         cnt <= 4'd0;
      end else if (cnt != 4'd0) cnt <= cnt - 4'd1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d,
                     input logic two);
      logic [7:0] x;
      logic a;
      M.start();
      M.xfer({DEV, 1'b0}, 1'b1, x, a);
      chk({7'h0, a}, 8'h00);
      M.xfer(p, 1'b1, x, a);
      chk({7'h0, a}, 8'h00);
      if (two) begin
         M.xfer(d, 1'b1, x, a);
         chk({7'h0, a}, 8'h00);
      end
      M.stop();
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] x;
      logic a;
      wr(p, 8'h00, 1'b0);
      M.start();
      M.xfer({DEV, 1'b1}, 1'b1, x, a);
      chk({7'h0, a}, 8'h00);
      M.xfer(8'hff, 1'b1, x, a);
      chk(x, e);
      M.stop();
   endtask
   task automatic end_sim();
      if (n_mismatch == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      standby_pin_n_n = 1'b0;
      pin_a = PIN_OPEN;
      pin_b = PIN_OPEN;
      loc = 8'h20;
      rem = 8'h12;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (40) @(negedge clk);
      for (int i = 0; i < 11; i++) rd(RA[i], RE[i]);
      for (int i = 0; i < 7; i++) begin
         wr(WA[i], WD[i], 1'b1);
         rd(WB[i], WE[i]);
      end
      rd(RD_RATE, 8'h07);
      standby_pin_n_n = 1'b1;
      pin_a = PIN_HIGH;
      pin_b = PIN_HIGH;
      repeat (200) @(negedge clk);
      rd(RD_LOCAL, 8'h80);
      wr(WR_ONESHOT, 8'h55, 1'b1);
      repeat (20) @(negedge clk);
      rd(RD_LOCAL, 8'h20);
      rd(RD_REMOTE, 8'h0e);
      rd(WR_ONESHOT, 8'h00);
      wr(WR_CONFIG, 8'h40, 1'b1);
      chk({7'h0, alert_n}, 8'h01);
      wr(WR_LHI, 8'h1f, 1'b1);
      wr(WR_ONESHOT, 8'h00, 1'b1);
      repeat (20) @(negedge clk);
      chk({7'h0, alert_n}, 8'h00);
      wr(WR_CONFIG, 8'hc0, 1'b1);
      chk({7'h0, alert_n}, 8'h01);
      wr(WR_LHI, 8'h7f, 1'b1);
      rd(RD_STATUS, 8'h40);
      rd(RD_STATUS, 8'h00);
      adc_open = 1'b1;
      wr(WR_ONESHOT, 8'h00, 1'b1);
      repeat (20) @(negedge clk);
      rd(RD_STATUS, 8'h04);
      adc_open = 1'b0;
      loc = 8'h33;
      wr(WR_CONFIG, 8'h80, 1'b1);
      repeat (100) @(negedge clk);
      rd(RD_LOCAL, 8'h33);
      standby_pin_n_n = 1'b0;
      repeat (10) @(negedge clk);
      loc = 8'h44;
      repeat (100) @(negedge clk);
      rd(RD_LOCAL, 8'h33);
      M.start();
      M.xfer({7'h4e, 1'b0}, 1'b1, q, ack);
      chk({7'h0, ack}, 8'h01);
      M.stop();
      end_sim();
   end
endmodule
`default_nettype wire
